// ### lcdc_core.sv
// serial receiver, command interpreter and display timing of the lcd controller
// assumes clk is the oscillator clock; all pins are asynchronous to it
`timescale 1ns/1ps
module lcdc_core #(
    parameter int unsigned BLINK_SLOW_HALF = 65536,
    parameter int unsigned BLINK_FAST_HALF = 32768
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        reset_pin_n,
    input  wire logic        cs_pin_n,
    input  wire logic        sck_pin,
    input  wire logic        si_pin,
    input  wire logic        cd_pin,
    output logic             busy_n_o,
    output logic             busy_n_oe,
    output logic [31:0]      segment_outputs,
    output logic [3:0]       common_outputs,
    output logic [1:0]       time_division_field,
    output logic             bias_select_bit,
    output logic [1:0]       frame_divider_field,
    output logic             display_on
);
    lcdc_pkg::lcdc_state_t q, n;
    lcdc_pkg::lcdc_pins_t  pins;
    logic [7:0]            dec_pat;
    logic [7:0]            wr_pat;
    logic                  cs_fall, cs_rise, sck_rise, frame_end;
    logic [10:0]           slot_last;
    logic [1:0]            slot_top;
    logic [15:0]           blink_last;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [10:0] slot_len_m1(input logic [1:0] fdiv);
        case (fdiv)
            2'h0:    slot_len_m1 = 11'((1 << lcdc_pkg::FRAME_SHIFT_00) - 1);
            2'h1:    slot_len_m1 = 11'((1 << lcdc_pkg::FRAME_SHIFT_01) - 1);
            2'h2:    slot_len_m1 = 11'((1 << lcdc_pkg::FRAME_SHIFT_10) - 1);
            default: slot_len_m1 = 11'((1 << lcdc_pkg::FRAME_SHIFT_11) - 1);
        endcase
    endfunction

    function automatic logic [1:0] last_common(input logic [1:0] tdiv);
        case (tdiv)
            lcdc_pkg::TDIV_STATIC: last_common = 2'h0;
            lcdc_pkg::TDIV_2:      last_common = 2'h1;
            lcdc_pkg::TDIV_3:      last_common = 2'h2;
            default:               last_common = 2'h3;
        endcase
    endfunction

    function automatic logic [3:0] nib_op(input logic [3:0] old, input logic [3:0] imm,
                                          input logic [7:0] op);
        if ((op & lcdc_pkg::MSK_HI4) inside {lcdc_pkg::OP_OR_DMEM, lcdc_pkg::OP_OR_BMEM})
            nib_op = old | imm;
        else if ((op & lcdc_pkg::MSK_HI4) inside {lcdc_pkg::OP_AND_DMEM, lcdc_pkg::OP_AND_BMEM})
            nib_op = old & imm;
        else
            nib_op = imm;
    endfunction

    lcdc_seg_decoder u_dec (
        .data_byte (q.cmd_byte),
        .pattern   (dec_pat)
    );

    assign pins = '{rst_n: reset_pin_n, cs_n: cs_pin_n, sck: sck_pin, si: si_pin, cd: cd_pin};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n = q;
        // three-stage synchroniser; a change counts once stages two and three agree
        n.s1 = pins;
        n.s2 = q.s1;
        n.s3 = q.s2;
        for (int i = 0; i < 5; i++) begin
            if (q.s2[i] == q.s3[i])
                n.flt[i] = q.s3[i];
        end
        cs_fall  = q.flt.cs_n & ~n.flt.cs_n;
        cs_rise  = ~q.flt.cs_n & n.flt.cs_n;
        sck_rise = ~q.flt.sck & n.flt.sck;
        wr_pat   = q.dec_en ? dec_pat : q.cmd_byte;

        // pin reset needs a run of low samples, so glitches do not reset the display
        if (n.flt.rst_n) begin
            n.rst_cnt = 4'h0;
            n.dev_rst = 1'b0;
        end else if (q.rst_cnt < 4'(lcdc_pkg::RST_LOW_CYCLES)) begin
            n.rst_cnt = q.rst_cnt + 4'h1;
            n.dev_rst = (n.rst_cnt == 4'(lcdc_pkg::RST_LOW_CYCLES));
        end

        // serial byte reception
        n.exec    = 1'b0;
        n.busy_oe = ~n.flt.cs_n;
        if (n.flt.cs_n) begin
            n.busy_n = 1'b0;
        end else if (cs_fall) begin
            n.busy_n = 1'b0;
            n.bitcnt = 3'h0;
            if (!q.keep_ptr)
                n.ptr = 5'h0;
            n.keep_ptr = 1'b0;
        end else if (sck_rise && q.busy_n) begin
            n.shreg  = {q.shreg[6:0], n.flt.si};
            n.bitcnt = q.bitcnt + 3'h1;
            if (q.bitcnt == 3'h7) begin
                n.busy_n   = 1'b0;
                n.cmd_byte = {q.shreg[6:0], n.flt.si};
                n.cmd_cd   = n.flt.cd;
                n.exec     = 1'b1;
            end
        end else if (!q.busy_n) begin
            n.busy_n = 1'b1;
        end

        // command interpreter, one cycle after the byte lands
        if (q.exec && q.cmd_cd) begin
            if ((q.cmd_byte & lcdc_pkg::MSK_HI3) == lcdc_pkg::OP_MODE_SET) begin
                n.mode = lcdc_pkg::lcdc_mode_t'(q.cmd_byte[4:0]);
                // static drive has no bias; stored already masked so the pin is a flop
                if (q.cmd_byte[1:0] == lcdc_pkg::TDIV_STATIC)
                    n.mode.bias_select_bit = 1'h0;
            end else if (q.cmd_byte == lcdc_pkg::OP_SYNC_XFER)
                n.sync_xfer = 1'b1;
            else if (q.cmd_byte == lcdc_pkg::OP_UNSYNC)
                n.sync_xfer = 1'b0;
            else if (q.cmd_byte == lcdc_pkg::OP_PAUSE)
                n.pause = 1'b1;
            else if ((q.cmd_byte & lcdc_pkg::MSK_HI7) == lcdc_pkg::OP_BLINK_ON) begin
                n.blink_en       = 1'b1;
                n.blink_rate_bit = q.cmd_byte[0];
            end else if (q.cmd_byte == lcdc_pkg::OP_BLINK_OFF)
                n.blink_en = 1'b0;
            else if (q.cmd_byte == lcdc_pkg::OP_DISP_ON)
                n.disp_on = 1'b1;
            else if (q.cmd_byte == lcdc_pkg::OP_DISP_OFF)
                n.disp_on = 1'b0;
            else if (q.cmd_byte == lcdc_pkg::OP_DEC_ON)
                n.dec_en = 1'b1;
            else if (q.cmd_byte == lcdc_pkg::OP_DEC_OFF)
                n.dec_en = 1'b0;
            else if ((q.cmd_byte & lcdc_pkg::MSK_HI3) == lcdc_pkg::OP_LOAD_PTR)
                n.ptr = q.cmd_byte[4:0];
            else if (q.cmd_byte == lcdc_pkg::OP_CLR_DMEM) begin
                n.dmem = '0;
                n.ptr  = 5'h0;
            end else if (q.cmd_byte == lcdc_pkg::OP_CLR_BMEM) begin
                n.bmem = '0;
                n.ptr  = 5'h0;
            end else if ((q.cmd_byte & lcdc_pkg::MSK_HI4) inside
                         {lcdc_pkg::OP_WR_DMEM, lcdc_pkg::OP_OR_DMEM, lcdc_pkg::OP_AND_DMEM}) begin
                n.dmem[q.ptr] = nib_op(q.dmem[q.ptr], q.cmd_byte[3:0], q.cmd_byte);
                n.ptr         = q.ptr + 5'h1;
            end else if ((q.cmd_byte & lcdc_pkg::MSK_HI4) inside
                         {lcdc_pkg::OP_WR_BMEM, lcdc_pkg::OP_OR_BMEM, lcdc_pkg::OP_AND_BMEM}) begin
                n.bmem[q.ptr] = nib_op(q.bmem[q.ptr], q.cmd_byte[3:0], q.cmd_byte);
                n.ptr         = q.ptr + 5'h1;
            end
        end else if (q.exec) begin
            // a display byte fills two words, low nibble first
            n.dmem[q.ptr]         = wr_pat[3:0];
            n.dmem[q.ptr + 5'h1]  = wr_pat[7:4];
            n.ptr                 = q.ptr + 5'h2;
        end

        // display timing: one slot per common, frame ends after the last common
        slot_last = slot_len_m1(q.mode.frame_divider_field);
        slot_top  = last_common(q.mode.time_division_field);
        frame_end = 1'b0;
        if (q.slot_cnt >= slot_last) begin
            n.slot_cnt = 11'h0;
            if (q.slot >= slot_top) begin
                n.slot    = 2'h0;
                frame_end = 1'b1;
            end else begin
                n.slot = q.slot + 2'h1;
            end
        end else begin
            n.slot_cnt = q.slot_cnt + 11'h1;
        end

        blink_last = q.blink_rate_bit ? 16'(BLINK_FAST_HALF - 1) : 16'(BLINK_SLOW_HALF - 1);
        if (q.blink_cnt >= blink_last) begin
            n.blink_cnt = 16'h0;
            n.blank     = ~q.blank;
        end else begin
            n.blink_cnt = q.blink_cnt + 16'h1;
        end

        // memory to latch copy; the latch keeps the blink marks beside the data
        if (cs_rise) begin
            if (q.pause) begin
                n.pause    = 1'b0;
                n.keep_ptr = 1'b1;
            end else if (q.sync_xfer) begin
                n.pend = 1'b1;
            end else begin
                n.dlat = q.dmem;
                n.blat = q.bmem;
            end
        end else if (q.pend && frame_end) begin
            n.pend = 1'b0;
            n.dlat = q.dmem;
            n.blat = q.bmem;
        end

        // segment and common drive
        for (int k = 0; k < 32; k++) begin
            n.seg[k] = q.dlat[k][q.slot] & ~(q.blink_en & q.blank & q.blat[k][q.slot]);
        end
        n.com = 4'(1) << q.slot;
        if (!q.disp_on) begin
            n.seg = '0;
            n.com = '0;
        end

        if (q.dev_rst) begin
            n.mode      = '0;
            n.sync_xfer = 1'b0;
            n.pause     = 1'b0;
            n.keep_ptr  = 1'b0;
            n.pend      = 1'b0;
            n.dec_en    = 1'b0;
            n.disp_on   = 1'b0;
            n.blink_en  = 1'b0;
            n.bitcnt    = 3'h0;
            n.exec      = 1'b0;
            n.busy_n    = 1'b0;
            n.seg       = '1;
            n.com       = '1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst)
            q <= lcdc_pkg::ST_RST;
        else
            q <= n;
    end

    assign busy_n_o            = q.busy_n;
    assign busy_n_oe           = q.busy_oe;
    assign segment_outputs     = q.seg;
    assign common_outputs      = q.com;
    assign time_division_field = q.mode.time_division_field;
    assign bias_select_bit     = q.mode.bias_select_bit;
    assign frame_divider_field = q.mode.frame_divider_field;
    assign display_on          = q.disp_on;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_rst_count;
        $rose(q.dev_rst) |-> $past(q.rst_cnt) == 4'(lcdc_pkg::RST_LOW_CYCLES - 1);
    endproperty
    a_rst_count: assert property (p_rst_count) else $error("reset taken too early");

    property p_rst_outputs;
        q.dev_rst |=> (q.seg == '1) && (q.com == '1) && !q.busy_n && !q.disp_on;
    endproperty
    a_rst_outputs: assert property (p_rst_outputs) else $error("reset drive wrong");

    property p_cs_fall;
        cs_fall && !q.dev_rst |=> !q.busy_n && (q.bitcnt == 3'h0) ##1 q.busy_n || q.flt.cs_n;
    endproperty
    a_cs_fall: assert property (p_cs_fall) else $error("select fall handling wrong");

    property p_no_shift_deselected;
        q.flt.cs_n |=> $stable(q.shreg);
    endproperty
    a_no_shift_deselected: assert property (p_no_shift_deselected)
        else $error("shift while deselected");

    property p_byte_done;
        q.exec |-> !q.busy_n && ($past(q.bitcnt) == 3'h7);
    endproperty
    a_byte_done: assert property (p_byte_done) else $error("byte end wrong");

    property p_unsync_copy;
        cs_rise && !q.pause && !q.sync_xfer && !q.dev_rst |=> q.dlat == $past(q.dmem);
    endproperty
    a_unsync_copy: assert property (p_unsync_copy) else $error("latch copy missed");

    property p_pause_skip;
        cs_rise && q.pause && !q.dev_rst |=> $stable(q.dlat) && q.keep_ptr && !q.pause;
    endproperty
    a_pause_skip: assert property (p_pause_skip) else $error("pause not honoured");

    property p_disp_off;
        !q.disp_on && !q.dev_rst |=> (q.seg == '0) && (q.com == '0);
    endproperty
    a_disp_off: assert property (p_disp_off) else $error("display off not blank");

    property p_ptr_inc;
        q.exec && q.cmd_cd && ((q.cmd_byte & lcdc_pkg::MSK_HI4) == lcdc_pkg::OP_WR_DMEM)
        && !q.dev_rst |=> q.ptr == $past(q.ptr) + 5'h1;
    endproperty
    a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not advanced");

    c_byte:  cover property (q.exec && q.cmd_cd);
    c_sync:  cover property (q.pend ##[1:300] !q.pend);
    c_blink: cover property (q.blink_en && $rose(q.blank));
endmodule // lcdc_core

// ### lcdc_pkg.sv
// shared constants and carrier types of the lcd serial command interface
// assumes one oscillator clock; all pins reach the core through lcdc_pins_t
package lcdc_pkg;

    // ------------------------------------------------------------
    // reset and timing
    // ------------------------------------------------------------
    localparam int unsigned RST_LOW_CYCLES = 12;
    localparam int unsigned FRAME_SHIFT_00 = 7;
    localparam int unsigned FRAME_SHIFT_01 = 8;
    localparam int unsigned FRAME_SHIFT_10 = 9;
    localparam int unsigned FRAME_SHIFT_11 = 11;

    // ------------------------------------------------------------
    // mode set field codes
    // ------------------------------------------------------------
    localparam logic [1:0] TDIV_4      = 2'h0;
    localparam logic [1:0] TDIV_STATIC = 2'h1;
    localparam logic [1:0] TDIV_3      = 2'h2;
    localparam logic [1:0] TDIV_2      = 2'h3;
    localparam logic       BIAS_THIRD  = 1'h0;
    localparam logic       BIAS_HALF   = 1'h1;

    // ------------------------------------------------------------
    // command opcodes, compared under their masks
    // ------------------------------------------------------------
    localparam logic [7:0] MSK_FULL     = 8'hFF;
    localparam logic [7:0] MSK_HI3      = 8'hE0;
    localparam logic [7:0] MSK_HI4      = 8'hF0;
    localparam logic [7:0] MSK_HI7      = 8'hFE;
    localparam logic [7:0] OP_MODE_SET  = 8'h40;
    localparam logic [7:0] OP_SYNC_XFER = 8'h31;
    localparam logic [7:0] OP_UNSYNC    = 8'h30;
    localparam logic [7:0] OP_PAUSE     = 8'h38;
    localparam logic [7:0] OP_BLINK_ON  = 8'h1A;
    localparam logic [7:0] OP_BLINK_OFF = 8'h18;
    localparam logic [7:0] OP_DISP_ON   = 8'h11;
    localparam logic [7:0] OP_DISP_OFF  = 8'h10;
    localparam logic [7:0] OP_DEC_ON    = 8'h15;
    localparam logic [7:0] OP_DEC_OFF   = 8'h14;
    localparam logic [7:0] OP_LOAD_PTR  = 8'hE0;
    localparam logic [7:0] OP_WR_DMEM   = 8'hD0;
    localparam logic [7:0] OP_OR_DMEM   = 8'hB0;
    localparam logic [7:0] OP_AND_DMEM  = 8'h90;
    localparam logic [7:0] OP_CLR_DMEM  = 8'h20;
    localparam logic [7:0] OP_WR_BMEM   = 8'hC0;
    localparam logic [7:0] OP_OR_BMEM   = 8'hA0;
    localparam logic [7:0] OP_AND_BMEM  = 8'h80;
    localparam logic [7:0] OP_CLR_BMEM  = 8'h00;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       bias_select_bit;
        logic [1:0] frame_divider_field;
        logic [1:0] time_division_field;
    } lcdc_mode_t;

    typedef struct packed {
        logic rst_n;
        logic cs_n;
        logic sck;
        logic si;
        logic cd;
    } lcdc_pins_t;

    typedef struct packed {
        lcdc_pins_t        s1, s2, s3, flt;
        logic [3:0]        rst_cnt;
        logic              dev_rst;
        logic [7:0]        shreg;
        logic [2:0]        bitcnt;
        logic              busy_n;
        logic              busy_oe;
        logic              exec;
        logic [7:0]        cmd_byte;
        logic              cmd_cd;
        lcdc_mode_t        mode;
        logic              sync_xfer, pause, keep_ptr, pend;
        logic              blink_en, blink_rate_bit, disp_on, dec_en;
        logic [4:0]        ptr;
        logic [31:0][3:0]  dmem, bmem, dlat, blat;
        logic [10:0]       slot_cnt;
        logic [1:0]        slot;
        logic [15:0]       blink_cnt;
        logic              blank;
        logic [31:0]       seg;
        logic [3:0]        com;
    } lcdc_state_t;

    // synchroniser stages start at the idle pin levels, so leaving sys_rst
    // shows no false select edge and does not start the reset-pin count
    localparam lcdc_pins_t PINS_IDLE = '{rst_n: 1'h1, cs_n: 1'h1, sck: 1'h1, si: 1'h0, cd: 1'h1};
    localparam lcdc_state_t ST_RST   = '{s1: PINS_IDLE, s2: PINS_IDLE, s3: PINS_IDLE,
                                         flt: PINS_IDLE, default: '0};

endpackage

// ### lcdc_seg_decoder.sv
// seven-segment pattern generator for incoming display bytes
// assumes the low nibble is a hex digit and bit 7 carries the decimal point
`timescale 1ns/1ps
module lcdc_seg_decoder (
    input  wire logic [7:0] data_byte,
    output logic      [7:0] pattern
);
    logic [6:0] segs;

    always_comb begin
        case (data_byte[3:0])
            4'h0: segs = 7'h3F;
            4'h1: segs = 7'h06;
            4'h2: segs = 7'h5B;
            4'h3: segs = 7'h4F;
            4'h4: segs = 7'h66;
            4'h5: segs = 7'h6D;
            4'h6: segs = 7'h7D;
            4'h7: segs = 7'h07;
            4'h8: segs = 7'h7F;
            4'h9: segs = 7'h6F;
            4'hA: segs = 7'h77;
            4'hB: segs = 7'h7C;
            4'hC: segs = 7'h39;
            4'hD: segs = 7'h5E;
            4'hE: segs = 7'h79;
            default: segs = 7'h71;
        endcase
        pattern = {data_byte[7], segs};
    end
endmodule // lcdc_seg_decoder

// ### lcdc_host_model.sv
// host side of the serial command link: select, shift clock, data, command/data
// assumes the hold-off line reads high when the device leaves it undriven
`timescale 1ns/1ps
module lcdc_host_model (
    input  wire logic clk,
    input  wire logic busy_n,
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    output logic      cd
);
    initial begin
        cs_n = 1'b1;
        sck  = 1'b1;
        si   = 1'b0;
        cd   = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // bounded wait; a hang is left to the bench watchdog
    task automatic wait_rdy();
        for (int i = 0; i < 300 && busy_n !== 1'b1; i++) tick(1);
    endtask
    task automatic sel();
        cs_n = 1'b0;
        tick(8);
        wait_rdy();
    endtask
    // select stays low across all bytes; released only between whole bytes
    task automatic send(input logic c, input logic [7:0] b);
        cd = c;
        for (int i = 7; i >= 0; i--) begin
            si  = b[i];
            sck = 1'b0;
            tick(5);
            sck = 1'b1;
            tick(5);
        end
        tick(8);
        si = ~si;
        wait_rdy();
    endtask
    task automatic desel();
        cs_n = 1'b1;
        tick(12);
    endtask
endmodule // lcdc_host_model

// ### lcd_serial_command_interface_tb_top.sv
// self-checking bench: host model drives the link, bench checks the pins
// assumes 40 MHz oscillator clock and shortened blink half-periods
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module lcd_serial_command_interface_tb_top;
    logic        clk, sys_rst, reset_pin_n, busy_o, busy_oe, bias, don;
    logic        cs_n, sck, si, cd;
    logic [31:0] seg;
    logic [3:0]  com;
    logic [1:0]  tdf, fdf;
    wire logic   busy_w = busy_oe ? busy_o : 1'b1;
    int          n_fail = 0;
    int          checks_done = 0;
    int          nz;
    lcdc_core #(.BLINK_SLOW_HALF(8), .BLINK_FAST_HALF(4)) dut (
        .clk(clk), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n), .cs_pin_n(cs_n),
        .sck_pin(sck), .si_pin(si), .cd_pin(cd), .busy_n_o(busy_o), .busy_n_oe(busy_oe),
        .segment_outputs(seg), .common_outputs(com), .time_division_field(tdf),
        .bias_select_bit(bias), .frame_divider_field(fdf), .display_on(don));
    lcdc_host_model host (.clk(clk), .busy_n(busy_w), .cs_n(cs_n), .sck(sck), .si(si),
        .cd(cd));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic end_of_test();
        if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] b);
        host.send(1'b1, b);
    endtask
    // segment k under common c shows latch word k bit c
    task automatic chk_segs(input logic [3:0] w0, input logic [3:0] w1, input logic [3:0] w31);
        for (int c = 0; c < 4; c++) begin
            for (int i = 0; i < 5000 && com !== 4'(1 << c); i++) host.tick(1);
            `CHK("seg", {w31[c], w1[c], w0[c]}, {seg[31], seg[1:0]})
        end
    endtask
    // dark cycles of segment 1 over 8 cycles under common 1
    task automatic cnt_dark(output int k);
        k = 0;
        for (int i = 0; i < 5000 && com !== 4'h2; i++) host.tick(1);
        for (int i = 0; i < 8; i++) begin
            k += (seg[1] === 1'b0);
            host.tick(1);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        end_of_test();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        reset_pin_n = 1'b1;
        host.tick(5);
        sys_rst = 1'b0;
        reset_pin_n = 1'b0;
        host.tick(8);
        reset_pin_n = 1'b1;
        host.tick(8);
        `CHK("short_rst", 32'h0, seg)
        reset_pin_n = 1'b0;
        host.tick(20);
        `CHK("rst_seg", 32'hFFFFFFFF, seg)
        `CHK("rst_com", 4'hF, com)
        `CHK("rst_busy", 1'b0, busy_o)
        reset_pin_n = 1'b1;
        host.tick(10);
        `CHK("rst_mode", 5'h0, {bias, fdf, tdf})
        `CHK("rst_disp", 1'b0, don)
        for (int m = 0; m < 4; m++) begin
            host.sel();
            cmd(8'h50 | 8'(m << 2) | 8'(m));
            host.desel();
            `CHK("tdiv", 2'(m), tdf)
            `CHK("fdiv", 2'(m), fdf)
            `CHK("bias", 2'(m) != lcdc_pkg::TDIV_STATIC, bias)
        end
        host.sel();
        `CHK("busy_oe", 1'b1, busy_oe)
        cmd(lcdc_pkg::OP_MODE_SET);
        cmd(lcdc_pkg::OP_CLR_DMEM);
        cmd(lcdc_pkg::OP_WR_DMEM | 8'h05);
        cmd(lcdc_pkg::OP_WR_DMEM | 8'h0A);
        cmd(lcdc_pkg::OP_LOAD_PTR | 8'h00);
        cmd(lcdc_pkg::OP_OR_DMEM | 8'h02);
        cmd(lcdc_pkg::OP_AND_DMEM | 8'h06);
        cmd(lcdc_pkg::OP_DISP_ON);
        host.desel();
        `CHK("disp", 1'b1, don)
        chk_segs(4'h7, 4'h2, 4'h0);
        host.sel();
        cmd(lcdc_pkg::OP_PAUSE);
        cmd(lcdc_pkg::OP_LOAD_PTR | 8'h00);
        cmd(lcdc_pkg::OP_WR_DMEM | 8'h00);
        host.desel();
        chk_segs(4'h7, 4'h2, 4'h0);
        host.sel();
        cmd(lcdc_pkg::OP_WR_DMEM | 8'h0F);
        host.desel();
        chk_segs(4'h0, 4'hF, 4'h0);
        // decoded byte at 31 wraps its high nibble to 0; raw byte follows at 1
        host.sel();
        cmd(lcdc_pkg::OP_DEC_ON);
        cmd(lcdc_pkg::OP_LOAD_PTR | 8'h1F);
        host.send(1'b0, 8'h01);
        cmd(lcdc_pkg::OP_DEC_OFF);
        host.send(1'b0, 8'h5A);
        cmd(lcdc_pkg::OP_SYNC_XFER);
        host.desel();
        host.tick(600);
        chk_segs(4'h0, 4'hA, 4'h6);
        host.sel();
        cmd(lcdc_pkg::OP_UNSYNC);
        cmd(lcdc_pkg::OP_LOAD_PTR | 8'h01);
        cmd(lcdc_pkg::OP_WR_BMEM | 8'h0F);
        cmd(lcdc_pkg::OP_BLINK_ON | 8'h01);
        host.desel();
        cnt_dark(nz);
        `CHK("blink", 4, nz)
        host.sel();
        cmd(lcdc_pkg::OP_BLINK_OFF);
        host.desel();
        cnt_dark(nz);
        `CHK("blink_off", 0, nz)
        host.sel();
        cmd(lcdc_pkg::OP_CLR_BMEM);
        cmd(lcdc_pkg::OP_BLINK_ON | 8'h01);
        host.desel();
        cnt_dark(nz);
        `CHK("bmem_clr", 0, nz)
        host.sel();
        cmd(lcdc_pkg::OP_DISP_OFF);
        host.desel();
        `CHK("disp_off", 1'b0, don)
        `CHK("com_off", 4'h0, com)
        end_of_test();
    end
endmodule // lcd_serial_command_interface_tb_top
